/* hw/imufr_regs.vh */
`ifndef IMUFR_REGS_VH
`define IMUFR_REGS_VH
// ==========================================================
// register offsets
`define IMUFR_OFF_STANDBY   7'h6c
`define IMUFR_OFF_HOST_IF   7'h70
`define IMUFR_OFF_LVL_HIGH  7'h72
`define IMUFR_OFF_LVL_LOW   7'h73
`define IMUFR_OFF_DATA      7'h74
`define IMUFR_OFF_IDENT     7'h75
`define IMUFR_OFF_XT_HIGH   7'h77
`define IMUFR_OFF_XT_LOW    7'h78
`define IMUFR_OFF_YT_HIGH   7'h7a
`define IMUFR_OFF_YT_LOW    7'h7b
`define IMUFR_OFF_ZT_HIGH   7'h7d
`define IMUFR_OFF_ZT_LOW    7'h7e
// ==========================================================
// field positions and masks
`define IMUFR_STBY_MASK     8'h3f
`define IMUFR_TWO_WIRE_BIT  6
`define IMUFR_TRIM_LOW_MASK 8'hfe
`define IMUFR_CAP_TEMP      7
`define IMUFR_CAP_GX        6
`define IMUFR_CAP_GY        5
`define IMUFR_CAP_GZ        4
`define IMUFR_CAP_ACCEL     3
// ==========================================================
// values
`define IMUFR_RST_BYTE      8'h00
`define IMUFR_EMPTY_BYTE    8'hff
`define IMUFR_CLAMP_BYTE    8'hfe
`define IMUFR_TWI_BASE      7'h68
`define IMUFR_PART_ID       8'ha5
// ==========================================================
// sensor byte walk: register 59 is byte 0, register 72 is byte 13
`define IMUFR_SEQ_LAST      4'hd
`define IMUFR_SEQ_TEMP_LO   4'h6
`define IMUFR_SEQ_GX_LO     4'h8
`define IMUFR_SEQ_GY_LO     4'ha
`define IMUFR_SEQ_GZ_LO     4'hc
`endif

/* hw/imufr_top.v */
`timescale 1ns/10ps
//Contract
//- six standby bits, accel xyz in 5..3, gyro xyz in 2..0; 1 is off
//- bit 6 of host interface register turns off the two-wire slave
//- queue byte count is 16 bits, high byte then low byte, read-only
//- reading the high count byte after reset or a low read latches both count bytes together
//- data port read pops one byte, write pushes one byte
//- on sample tick enabled sensor bytes pushed in register order
//- accel and gyro bytes are pushed only when their capture enable is set
//- overflow sets the overrun status flag
//- overflow drops oldest byte unless stop-on-full, which drops new data
//- reading the empty queue returns 0xff until new data arrives
//- sample data never enters the queue as 0xff
//- read-only identity register with fixed part value
//- two-wire address picked by the address select pin level
//- 15-bit accel trims, high byte 14..7, low byte 6..0 in bits 7..1
//- trim step 0.98 mg, range 16 g in every full-scale mode
//- all six off and sleep low: sensors off, master clock kept running
//- temperature pushed unless temp off, when its own capture enable is set or an accel/gyro capture enable is set with a sensor active
`include "imufr_regs.vh"

module imufr_top #(
  parameter         DEPTH   = 1024,
  parameter         AW      = 10,
  parameter [7:0]   PART_ID = `IMUFR_PART_ID  // arbitrary value
) (
  // clock and reset
  input  wire         CLK_I,
  input  wire         RST_N_I,
  // register port from the serial front end
  input  wire [6:0]   REG_ADDR_I,
  input  wire         REG_WR_I,
  input  wire         REG_RD_I,
  input  wire [7:0]   REG_WDATA_I,
  output reg  [7:0]   REG_RDATA_O,
  // sample path
  input  wire         SAMPLE_TICK_I,
  input  wire [111:0] SENSOR_DATA_I,
  input  wire [7:0]   CAPTURE_EN_I,
  input  wire         STOP_ON_FULL_I,
  input  wire         TEMP_OFF_I,
  input  wire         SLEEP_I,
  input  wire         OVERRUN_CLR_I,
  output reg          QUEUE_OVERRUN_FLAG_O,
  // pins and power controls
  input  wire         ADDRESS_SELECT_PIN_I,
  output reg  [6:0]   TWI_ADDR_O,
  output wire         TWO_WIRE_SLAVE_ON_O,
  output wire [2:0]   ACCEL_ON_O,
  output wire [2:0]   GYRO_ON_O,
  output wire         SENSORS_OFF_O,
  output wire         MASTER_CLK_ON_O,
  // accel offset trims, 0.98 mg per step
  output wire [14:0]  ACCEL_X_TRIM_O,
  output wire [14:0]  ACCEL_Y_TRIM_O,
  output wire [14:0]  ACCEL_Z_TRIM_O
);

  // ========================================================
  // register state
  reg  [5:0]    standby_q;
  reg           two_wire_off_q;
  reg  [14:0]   trim_x_q;
  reg  [14:0]   trim_y_q;
  reg  [14:0]   trim_z_q;
  reg  [15:0]   lvl_snap_q;
  reg           lvl_fresh_q;
  reg           sel_meta_q;
  reg           sel_sync_q;

  wire wr_hit = REG_WR_I;
  wire rd_hit = REG_RD_I;

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      standby_q      <= 6'h00;
      two_wire_off_q <= 1'b0;
      trim_x_q       <= 15'h0000;
      trim_y_q       <= 15'h0000;
      trim_z_q       <= 15'h0000;
    end else if (wr_hit) begin
      case (REG_ADDR_I)
        `IMUFR_OFF_STANDBY: begin
          standby_q <= REG_WDATA_I[5:0];
        end
        `IMUFR_OFF_HOST_IF: begin
          two_wire_off_q <= REG_WDATA_I[`IMUFR_TWO_WIRE_BIT];
        end
        // low bytes keep bits 7..1 only; bit 0 is reserved
        `IMUFR_OFF_XT_HIGH: trim_x_q[14:7] <= REG_WDATA_I;
        `IMUFR_OFF_XT_LOW:  trim_x_q[6:0]  <= REG_WDATA_I[7:1];
        `IMUFR_OFF_YT_HIGH: trim_y_q[14:7] <= REG_WDATA_I;
        `IMUFR_OFF_YT_LOW:  trim_y_q[6:0]  <= REG_WDATA_I[7:1];
        `IMUFR_OFF_ZT_HIGH: trim_z_q[14:7] <= REG_WDATA_I;
        `IMUFR_OFF_ZT_LOW:  trim_z_q[6:0]  <= REG_WDATA_I[7:1];
        // read-only and unmapped offsets land here and change nothing
        default: begin
        end
      endcase
    end
  end

  // the trims feed the offset adder as-is: one code step is 0.98 mg
  assign ACCEL_X_TRIM_O = trim_x_q;
  assign ACCEL_Y_TRIM_O = trim_y_q;
  assign ACCEL_Z_TRIM_O = trim_z_q;

  // ========================================================
  // power and interface controls
  assign ACCEL_ON_O = ~standby_q[5:3];
  assign GYRO_ON_O  = ~standby_q[2:0];
  assign SENSORS_OFF_O   = &standby_q;
  // all axes off is not sleep: the master clock stops only on sleep
  assign MASTER_CLK_ON_O = ~SLEEP_I;
  assign TWO_WIRE_SLAVE_ON_O = ~two_wire_off_q;

  // ========================================================
  // address select pin, two flops before use
  // the new address shows three edges after the pin settles
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
      TWI_ADDR_O <= `IMUFR_TWI_BASE;
    end else begin
      sel_meta_q <= ADDRESS_SELECT_PIN_I;
      sel_sync_q <= sel_meta_q;
      TWI_ADDR_O <= `IMUFR_TWI_BASE | {6'h00, sel_sync_q};
    end
  end

  // ========================================================
  // queue storage
  reg  [7:0]    mem_q [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr_q;
  reg  [AW-1:0] rd_ptr_q;
  reg  [AW:0]   count_q;

  wire empty = (count_q == {(AW+1){1'b0}});
  // the count is one bit wider than the pointers, so full and empty differ
  wire full  = (count_q == DEPTH[AW:0]);

  // ========================================================
  // sample walk over the fourteen sensor bytes
  reg           seq_busy_q;
  reg  [3:0]    seq_idx_q;
  reg           byte_en;
  wire          any_active = ~(&standby_q);
  wire          any_cap    = |CAPTURE_EN_I[`IMUFR_CAP_GX:`IMUFR_CAP_ACCEL];
  wire          temp_en    = ~TEMP_OFF_I & (CAPTURE_EN_I[`IMUFR_CAP_TEMP] |
                             (any_cap & any_active));
  wire [7:0]    seq_raw    = SENSOR_DATA_I[{seq_idx_q, 3'b000} +: 8];
  // 0xff would be mistaken for empty, so it is nudged one code down
  wire [7:0]    seq_byte   = (seq_raw == `IMUFR_EMPTY_BYTE) ?
                             `IMUFR_CLAMP_BYTE : seq_raw;

  always @* begin
    if (seq_idx_q < `IMUFR_SEQ_TEMP_LO) begin
      byte_en = CAPTURE_EN_I[`IMUFR_CAP_ACCEL];
    end else if (seq_idx_q < `IMUFR_SEQ_GX_LO) begin
      byte_en = temp_en;
    end else if (seq_idx_q < `IMUFR_SEQ_GY_LO) begin
      byte_en = CAPTURE_EN_I[`IMUFR_CAP_GX];
    end else if (seq_idx_q < `IMUFR_SEQ_GZ_LO) begin
      byte_en = CAPTURE_EN_I[`IMUFR_CAP_GY];
    end else begin
      byte_en = CAPTURE_EN_I[`IMUFR_CAP_GZ];
    end
  end

  // a host write to the data port takes the slot; the walk waits a cycle
  // host bytes are stored unclamped, so a written 0xff looks like empty
  wire host_push = wr_hit & (REG_ADDR_I == `IMUFR_OFF_DATA);
  wire seq_step  = seq_busy_q & ~host_push;
  wire seq_push  = seq_step & byte_en;
  wire push      = host_push | seq_push;
  wire [7:0] push_byte = host_push ? REG_WDATA_I : seq_byte;
  wire pop       = rd_hit & (REG_ADDR_I == `IMUFR_OFF_DATA) & ~empty;
  // a pop in the same cycle makes room, so that push is no overflow
  wire over      = push & full & ~pop;
  // stop-on-full loses the new byte but still raises the overrun flag
  wire do_write  = push & ~(over & STOP_ON_FULL_I);
  wire drop_old  = over & ~STOP_ON_FULL_I;

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      seq_busy_q <= 1'b0;
      seq_idx_q  <= 4'h0;
    end else if (!seq_busy_q) begin
      if (SAMPLE_TICK_I) begin
        seq_busy_q <= 1'b1;
        seq_idx_q  <= 4'h0;
      end
    end else if (seq_step) begin
      if (seq_idx_q == `IMUFR_SEQ_LAST) begin
        seq_busy_q <= 1'b0;
        // park on byte 0 so the byte select never runs past the bus
        seq_idx_q  <= 4'h0;
      end else begin
        seq_idx_q <= seq_idx_q + 4'h1;
      end
    end
  end

  // storage has no reset: count and pointers alone say what is valid
  always @(posedge CLK_I) begin
    if (do_write) begin
      mem_q[wr_ptr_q] <= push_byte;
    end
  end

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (do_write) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop | drop_old) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      // a full queue that drops its oldest byte keeps the same count
      if (do_write & ~pop & ~drop_old) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~do_write) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // sticky overrun flag, a new overflow beats a clear in the same cycle
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      QUEUE_OVERRUN_FLAG_O <= 1'b0;
    end else if (over) begin
      QUEUE_OVERRUN_FLAG_O <= 1'b1;
    end else if (OVERRUN_CLR_I) begin
      QUEUE_OVERRUN_FLAG_O <= 1'b0;
    end
  end

  // ========================================================
  // count snapshot: a high read refreshes only after reset or a low read
  // a host that skips the low read keeps seeing the old pair
  wire [15:0] live_count = {{(15-AW){1'b0}}, count_q};
  wire rd_high = rd_hit & (REG_ADDR_I == `IMUFR_OFF_LVL_HIGH);
  wire rd_low  = rd_hit & (REG_ADDR_I == `IMUFR_OFF_LVL_LOW);

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      // fresh from reset, so the first high read takes a live count
      lvl_snap_q  <= 16'h0000;
      lvl_fresh_q <= 1'b1;
    end else if (rd_high & lvl_fresh_q) begin
      lvl_snap_q  <= live_count;
      lvl_fresh_q <= 1'b0;
    end else if (rd_low) begin
      lvl_fresh_q <= 1'b1;
    end
  end

  // ========================================================
  // read data, one cycle after the strobe
  reg [7:0] rd_d;

  always @* begin
    case (REG_ADDR_I)
      `IMUFR_OFF_STANDBY: rd_d = {2'b00, standby_q};
      `IMUFR_OFF_HOST_IF: rd_d = {1'b0, two_wire_off_q, 6'h00};
      `IMUFR_OFF_LVL_HIGH: begin
        rd_d = lvl_fresh_q ? live_count[15:8] : lvl_snap_q[15:8];
      end
      `IMUFR_OFF_LVL_LOW: rd_d = lvl_snap_q[7:0];
      `IMUFR_OFF_DATA: begin
        rd_d = empty ? `IMUFR_EMPTY_BYTE : mem_q[rd_ptr_q];
      end
      `IMUFR_OFF_IDENT:   rd_d = PART_ID;
      `IMUFR_OFF_XT_HIGH: rd_d = trim_x_q[14:7];
      `IMUFR_OFF_XT_LOW:  rd_d = {trim_x_q[6:0], 1'b0};
      `IMUFR_OFF_YT_HIGH: rd_d = trim_y_q[14:7];
      `IMUFR_OFF_YT_LOW:  rd_d = {trim_y_q[6:0], 1'b0};
      `IMUFR_OFF_ZT_HIGH: rd_d = trim_z_q[14:7];
      `IMUFR_OFF_ZT_LOW:  rd_d = {trim_z_q[6:0], 1'b0};
      default:            rd_d = `IMUFR_RST_BYTE;
    endcase
  end

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= `IMUFR_RST_BYTE;
    end else if (rd_hit) begin
      // holds between reads, so a slow front end may take it late
      REG_RDATA_O <= rd_d;
    end
  end

endmodule // imufr_top

/* testbench/imufr_checker.sv */
`timescale 1ns/10ps
// ==========================================================
// port checker
module imufr_checker #(
  parameter [7:0] PART_ID = 8'ha5  // arbitrary value
) (
  // clock, reset and register port
  input wire        CLK_I,
  input wire        RST_N_I,
  input wire [6:0]  REG_ADDR_I,
  input wire        REG_WR_I,
  input wire        REG_RD_I,
  input wire [7:0]  REG_WDATA_I,
  input wire [7:0]  REG_RDATA_O,
  // controls and status
  input wire        SLEEP_I,
  input wire        OVERRUN_CLR_I,
  input wire        QUEUE_OVERRUN_FLAG_O,
  input wire        ADDRESS_SELECT_PIN_I,
  input wire [6:0]  TWI_ADDR_O,
  input wire        TWO_WIRE_SLAVE_ON_O,
  input wire [2:0]  ACCEL_ON_O,
  input wire [2:0]  GYRO_ON_O,
  input wire        SENSORS_OFF_O,
  input wire        MASTER_CLK_ON_O,
  input wire [14:0] ACCEL_X_TRIM_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_standby_map: assert property (
    REG_WR_I && REG_ADDR_I == 7'h6c |=>
    {2'b00, ~ACCEL_ON_O, ~GYRO_ON_O} == ($past(REG_WDATA_I) & 8'h3f))
    else $error("standby");
  a_slave_off: assert property (
    REG_WR_I && REG_ADDR_I == 7'h70 |=>
    {1'b0, !TWO_WIRE_SLAVE_ON_O, 6'h00} == ($past(REG_WDATA_I) & 8'h40))
    else $error("slave off");
  a_all_off_clk: assert property (SENSORS_OFF_O ==
    ({ACCEL_ON_O, GYRO_ON_O} == 6'h00) && MASTER_CLK_ON_O == !SLEEP_I)
    else $error("all off");
  a_ident_read: assert property (REG_RD_I && REG_ADDR_I == 7'h75 |=>
    REG_RDATA_O == PART_ID) else $error("identity");
  a_trim_low: assert property (
    REG_WR_I && REG_ADDR_I == 7'h78 |=>
    {ACCEL_X_TRIM_O[6:0], 1'b0} == ($past(REG_WDATA_I) & 8'hfe))
    else $error("trim low");
  a_trim_high: assert property (REG_WR_I && REG_ADDR_I == 7'h77 |=>
    ACCEL_X_TRIM_O[14:7] == $past(REG_WDATA_I)) else $error("trim high");
  a_twi_pick: assert property ($stable(ADDRESS_SELECT_PIN_I)[*6] |->
    TWI_ADDR_O == {6'h34, ADDRESS_SELECT_PIN_I}) else $error("twi addr");
  a_flag_sticky: assert property (
    QUEUE_OVERRUN_FLAG_O && !OVERRUN_CLR_I |=> QUEUE_OVERRUN_FLAG_O)
    else $error("flag lost");
  a_rsv_zero: assert property (REG_RD_I && REG_ADDR_I == 7'h70 |=>
    (REG_RDATA_O & 8'hbf) == 8'h00) else $error("reserved bits");
  c_flag: cover property ($rose(QUEUE_OVERRUN_FLAG_O));
  c_off: cover property (SENSORS_OFF_O);
  c_id: cover property (REG_RD_I && REG_ADDR_I == 7'h75);
endmodule // imufr_checker
bind imufr_top imufr_checker #(.PART_ID(PART_ID)) imufr_checker_inst (.*);

/* testbench/imufr_host.sv */
`timescale 1ns/10ps
// ==========================================================
// host side of the register port
module imufr_host (
  // clock
  input  wire       clk_i,
  // register port
  output reg  [6:0] addr_o = 7'h00,
  output reg        wr_o = 1'b0,
  output reg        rd_o = 1'b0,
  output reg  [7:0] wdata_o = 8'h00,
  input  wire [7:0] rdata_i
);
  // strobes move on the falling edge and last one rising edge
  task wr_reg(input [6:0] a, input [7:0] v);
    begin
      @(negedge clk_i);
      addr_o = a;
      wdata_o = v;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~v;  // released data flips so stale values cannot match
    end
  endtask
  task rd_reg(input [6:0] a, output [7:0] v);
    begin
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      v = rdata_i;
    end
  endtask
  // low byte read re-arms a fresh capture for the next pair
  task rd_level(output [15:0] v);
    begin
      rd_reg(7'h72, v[15:8]);
      rd_reg(7'h73, v[7:0]);
    end
  endtask
endmodule // imufr_host

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // stimulus and wires
  reg          clk = 1'b0;
  reg          rst_n = 1'b0;
  reg          tick = 1'b0, sof = 1'b0, toff = 1'b1;
  reg          sleep = 1'b0, oclr = 1'b0, pin = 1'b0;
  reg  [7:0]   cap = 8'h08;
  reg  [111:0] sdata;
  reg  [7:0]   d;
  reg  [15:0]  n;
  wire [6:0]   addr, twi;
  wire [7:0]   wdata, rdata;
  wire [2:0]   acc, gyr;
  wire [14:0]  xt, yt, zt;
  wire         wr, rd, flag, two, soff, clkon;
  integer      n_errors = 0, tests_run = 0, i;
  localparam [7:0] ID = 8'h5a;  // arbitrary value
  // temperature, gyro x and gyro z bytes in register order
  localparam [47:0] WALK = 48'h1617_1819_1c1d;
  always #4 clk = ~clk;
  imufr_host imufr_host_inst (.clk_i(clk), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata));
  // small depth so overflow is reached in a few samples
  imufr_top #(.DEPTH(8), .AW(3), .PART_ID(ID)) imufr_top_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .SAMPLE_TICK_I(tick), .SENSOR_DATA_I(sdata), .CAPTURE_EN_I(cap),
    .STOP_ON_FULL_I(sof), .TEMP_OFF_I(toff), .SLEEP_I(sleep),
    .OVERRUN_CLR_I(oclr), .QUEUE_OVERRUN_FLAG_O(flag),
    .ADDRESS_SELECT_PIN_I(pin), .TWI_ADDR_O(twi),
    .TWO_WIRE_SLAVE_ON_O(two), .ACCEL_ON_O(acc), .GYRO_ON_O(gyr),
    .SENSORS_OFF_O(soff), .MASTER_CLK_ON_O(clkon),
    .ACCEL_X_TRIM_O(xt), .ACCEL_Y_TRIM_O(yt), .ACCEL_Z_TRIM_O(zt));
  // ==========================================================
  // reporting
  task check(input [15:0] seen, input [15:0] exp, input [63:0] what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    begin
      imufr_host_inst.wr_reg(7'h6c, 8'hff);
      imufr_host_inst.rd_reg(7'h6c, d);
      check(d, 8'h3f, "standby");
      check({acc, gyr, soff, clkon}, 8'h03, "axes");
      sleep = 1'b1;
      @(negedge clk);
      check({soff, clkon}, 2'b10, "allOff");
      sleep = 1'b0;
      imufr_host_inst.wr_reg(7'h6c, 8'h29);
      check({acc, gyr, soff}, 7'h2c, "axesMix");
      imufr_host_inst.wr_reg(7'h70, 8'hff);
      imufr_host_inst.rd_reg(7'h70, d);
      check({d, two}, 9'h080, "hostIf");
      imufr_host_inst.rd_reg(7'h75, d);
      check(d, ID, "ident");
      imufr_host_inst.wr_reg(7'h77, 8'hc3);
      imufr_host_inst.wr_reg(7'h78, 8'hff);
      imufr_host_inst.rd_reg(7'h78, d);
      check(xt, 15'h61ff, "xtrim");
      check(d, 8'hfe, "xlow");
      imufr_host_inst.wr_reg(7'h7a, 8'h81);
      imufr_host_inst.wr_reg(7'h7b, 8'h03);
      imufr_host_inst.wr_reg(7'h7d, 8'h7f);
      imufr_host_inst.wr_reg(7'h7e, 8'h80);
      check(yt, 15'h4081, "ytrim");
      check(zt, 15'h3fc0, "ztrim");
      imufr_host_inst.rd_reg(7'h7f, d);
      check(d, 8'h00, "unmapped");
      pin = 1'b1;
      repeat (4) @(negedge clk);
      check(twi, 7'h69, "twiAddr");
      $display("done registers");
    end
  endtask
  task t_queue;
    begin
      imufr_host_inst.rd_reg(7'h74, d);
      check(d, 8'hff, "empty");
      for (i = 0; i < 3; i = i + 1)
        imufr_host_inst.wr_reg(7'h74, 8'h20 + i[7:0]);
      imufr_host_inst.rd_level(n);
      check(n, 16'd3, "level");
      imufr_host_inst.rd_reg(7'h72, d);
      imufr_host_inst.rd_reg(7'h74, d);
      check(d, 8'h20, "pop");
      imufr_host_inst.rd_reg(7'h73, d);
      check(d, 8'h03, "snapshot");
      imufr_host_inst.rd_level(n);
      check(n, 16'd2, "level");
      for (i = 0; i < 3; i = i + 1) begin
        imufr_host_inst.rd_reg(7'h74, d);
        check(d, (i < 2) ? 8'h21 + i[7:0] : 8'hff, "drain");
      end
      $display("done queue port");
    end
  endtask
  task fill(input integer k);
    begin
      repeat (k) begin
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        repeat (16) @(negedge clk);
      end
    end
  endtask
  task t_sample;
    begin
      fill(1);
      imufr_host_inst.rd_level(n);
      check(n, 16'd6, "level");
      for (i = 0; i < 6; i = i + 1) begin
        imufr_host_inst.rd_reg(7'h74, d);
        check(d, (i > 0) ? 8'h10 + i[7:0] : 8'hfe, "order");
      end
      fill(2);
      imufr_host_inst.rd_level(n);
      check(n, 16'd8, "full");
      check(flag, 1'b1, "overrun");
      imufr_host_inst.rd_reg(7'h74, d);
      check(d, 8'h14, "oldest");
      oclr = 1'b1;
      @(negedge clk);
      oclr = 1'b0;
      check(flag, 1'b0, "clear");
      for (i = 0; i < 7; i = i + 1)
        imufr_host_inst.rd_reg(7'h74, d);
      sof = 1'b1;
      fill(2);
      imufr_host_inst.rd_reg(7'h74, d);
      check(d, 8'hfe, "stopFull");
      check(flag, 1'b1, "overrun");
      $display("done sample path");
    end
  endtask
  task t_walk;
    begin
      for (i = 0; i < 7; i = i + 1)
        imufr_host_inst.rd_reg(7'h74, d);
      sof = 1'b0;
      toff = 1'b0;
      cap = 8'h50;
      fill(1);
      imufr_host_inst.rd_level(n);
      check(n, 16'd6, "tempLvl");
      for (i = 0; i < 6; i = i + 1) begin
        imufr_host_inst.rd_reg(7'h74, d);
        check(d, WALK[8*(5-i) +: 8], "walk");
      end
      $display("done gyro and temperature walk");
    end
  endtask
  // ==========================================================
  // sequence and watchdog
  initial begin
    for (i = 0; i < 14; i = i + 1)
      sdata[8*i +: 8] = 8'h10 + i[7:0];
    sdata[7:0] = 8'hff;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    t_queue;
    t_sample;
    t_walk;
    give_verdict;
  end
  initial begin
    #200000;
    n_errors = n_errors + 1;
    give_verdict;
  end
endmodule // testbench
